// ===== core/rdp_defs.vh
/*
 * Constants of the region decode and protection block: area bases, sizes,
 * slot geometry, permission encodings and response codes.
 * Assumes a 32-bit byte address from the requesting masters.
 */
`ifndef RDP_DEFS_VH
`define RDP_DEFS_VH

// Target area bases and address bits that select them.
`define RDP_FLASH_BASE 32'h0000_0000
`define RDP_FLASH_BITS 19
`define RDP_SRAM0_BASE 32'h1000_0000
`define RDP_SRAM0_BITS 15
`define RDP_SRAM1_BASE 32'h2007_C000
`define RDP_SRAM_BLK_BITS 14
`define RDP_APB_BASE 32'h4000_0000
`define RDP_APB_BITS 20
`define RDP_AHB_BASE 32'h5000_0000
`define RDP_AHB_BITS 21

// Every peripheral slot is a 16 kB window.
`define RDP_SLOT_BITS 14
`define RDP_AHB_SLOT_W 7
`define RDP_APB_SLOT_W 6

// Target codes.
`define RDP_TGT_NONE 3'h0
`define RDP_TGT_FLASH 3'h1
`define RDP_TGT_SRAM0 3'h2
`define RDP_TGT_SRAM1 3'h3
`define RDP_TGT_APB 3'h4
`define RDP_TGT_AHB 3'h5

// Region permission codes.
`define RDP_PERM_NONE 2'h0
`define RDP_PERM_RO 2'h1
`define RDP_PERM_RW 2'h2

// Answer codes.
`define RDP_RESP_OKAY 1'b0
`define RDP_RESP_ERROR 1'b1

// Vector area size, in address bits, that the remap redirects.
`define RDP_VEC_BITS 9

`endif

// ===== core/rdp_region_match.v
/*
 * One protection region comparator: power-of-two sized, size-aligned region
 * with eight equal subregions when 256 bytes or larger, each of which may be excluded.
 * Assumes configuration is stable while accesses run.
 */
`include "rdp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rdp_region_match (
    input wire [31:0] addr,
    input wire enable,
    input wire [31:0] base,
    input wire [4:0] size_log2,
    input wire [7:0] sub_disable,
    output reg hit
);
    reg [31:0] mask;
    reg [2:0] sub_idx;

    // Regions smaller than 256 bytes have no subregions; a size of 8 is the least.
    always @* begin
        mask = 32'hffff_ffff << size_log2;
        sub_idx = 3'h0;
        if (size_log2 >= 5'd8) begin
            sub_idx = addr[size_log2 - 5'd3 +: 3];
        end
        hit = enable && ((addr & mask) == (base & mask)) && !sub_disable[sub_idx];
    end
endmodule
`default_nettype wire

// ===== core/rdp_top.v
/*
 * Region decoder and protection checker placed between one bus master and
 * the targets. One access is taken per cycle and answered a cycle later.
 * Assumes masters hold request fields valid with req; several instances
 * serve several masters side by side.
 */
// Operation
// - Decode 2 MB fast peripheral area into 128 slots, route access.
// - Decode 1 MB slow peripheral area into 64 slots, route access.
// - Every slot is a 16 kB aligned window; index from address bits.
// - Decode main 32 kB SRAM and two 16 kB SRAM blocks.
// - Masters on different slave ports proceed in the same cycle.
// - Decode program flash of up to 512 kB as its own target.
// - Vector area fetches may be remapped to a configured base.
// - Eight regions; those of 256 bytes or more have eight individually excludable subregions.
// - Access outside every enabled region raises a fault.
// - Access forbidden by matching region permission raises a fault.
// - Read-only regions allow reads and refuse writes.
// - No-access regions refuse every access.
`include "rdp_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module rdp_top #(
    parameter NREG = 8
) (
    input wire clk,
    input wire reset,
    input wire req,
    input wire [31:0] addr,
    input wire write,
    input wire vec_fetch,
    input wire remap_en,
    input wire [31:0] remap_base,
    input wire [NREG-1:0] reg_enable,
    input wire [NREG*32-1:0] reg_base,
    input wire [NREG*5-1:0] reg_size,
    input wire [NREG*8-1:0] reg_subdis,
    input wire [NREG*2-1:0] reg_perm,
    output reg tgt_valid_q,
    output reg [2:0] tgt_sel_q,
    output reg [6:0] tgt_slot_q,
    output reg [31:0] tgt_addr_q,
    output reg tgt_write_q,
    output reg resp_valid_q,
    output reg resp_q,
    output reg fault_q
);
    wire [NREG-1:0] hits;
    reg [31:0] eff_addr;
    reg [2:0] sel;
    reg [6:0] slot;
    reg [1:0] perm;
    reg any_hit;
    reg allowed;
    integer i;

    // Area bases as sized constants, so that their upper bits can be sliced.
    localparam [31:0] FLASH_BASE = `RDP_FLASH_BASE;
    localparam [31:0] SRAM0_BASE = `RDP_SRAM0_BASE;
    localparam [31:0] SRAM1_BASE = `RDP_SRAM1_BASE;
    localparam [31:0] APB_BASE = `RDP_APB_BASE;
    localparam [31:0] AHB_BASE = `RDP_AHB_BASE;
    // The two RAM blocks straddle a 32 kB boundary, so they are found by offset, not by a bit match.
    localparam [31:0] SRAM1_SPAN = 32'h0000_0001 << (`RDP_SRAM_BLK_BITS + 1);

    // One comparator per region.
    genvar g;
    generate
        for (g = 0; g < NREG; g = g + 1) begin : g_reg
            rdp_region_match u_match (
                .addr(eff_addr),
                .enable(reg_enable[g]),
                .base(reg_base[g*32 +: 32]),
                .size_log2(reg_size[g*5 +: 5]),
                .sub_disable(reg_subdis[g*8 +: 8]),
                .hit(hits[g])
            );
        end
    endgenerate

    // Vector fetches in the low area are redirected to the remap base.
    always @* begin
        eff_addr = addr;
        if (vec_fetch && remap_en && (addr[31:`RDP_VEC_BITS] == 23'h00_0000)) begin
            eff_addr = {remap_base[31:`RDP_VEC_BITS], addr[`RDP_VEC_BITS-1:0]};
        end
    end

    // Target decode; slot numbers come straight from bits above the 16 kB offset.
    always @* begin
        sel = `RDP_TGT_NONE;
        slot = 7'h00;
        if (eff_addr[31:`RDP_FLASH_BITS] == FLASH_BASE[31:`RDP_FLASH_BITS]) begin
            sel = `RDP_TGT_FLASH;
        end else if (eff_addr[31:`RDP_SRAM0_BITS] == SRAM0_BASE[31:`RDP_SRAM0_BITS]) begin
            sel = `RDP_TGT_SRAM0;
        end else if ((eff_addr - SRAM1_BASE) < SRAM1_SPAN) begin
            sel = `RDP_TGT_SRAM1;
            slot = {6'h00, eff_addr[`RDP_SRAM_BLK_BITS]};
        end else if (eff_addr[31:`RDP_APB_BITS] == APB_BASE[31:`RDP_APB_BITS]) begin
            sel = `RDP_TGT_APB;
            slot = {1'b0, eff_addr[`RDP_SLOT_BITS +: `RDP_APB_SLOT_W]};
        end else if (eff_addr[31:`RDP_AHB_BITS] == AHB_BASE[31:`RDP_AHB_BITS]) begin
            sel = `RDP_TGT_AHB;
            slot = eff_addr[`RDP_SLOT_BITS +: `RDP_AHB_SLOT_W];
        end
    end

    // Highest numbered matching region decides, as is usual for overlaps.
    always @* begin
        any_hit = 1'b0;
        perm = `RDP_PERM_NONE;
        for (i = 0; i < NREG; i = i + 1) begin
            if (hits[i]) begin
                any_hit = 1'b1;
                perm = reg_perm[i*2 +: 2];
            end
        end
        case (perm)
            `RDP_PERM_RO: allowed = !write;
            `RDP_PERM_RW: allowed = 1'b1;
            `RDP_PERM_NONE: allowed = 1'b0;
            default: allowed = 1'b0;
        endcase
        allowed = allowed && any_hit && (sel != `RDP_TGT_NONE);
    end

    // Register stage. This instance never waits on another master's path, so
    // parallel instances run concurrently on distinct slave ports.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tgt_valid_q <= 1'b0;
            tgt_sel_q <= `RDP_TGT_NONE;
            tgt_slot_q <= 7'h00;
            tgt_addr_q <= 32'h0000_0000;
            tgt_write_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_q <= `RDP_RESP_OKAY;
            fault_q <= 1'b0;
        end else begin
            tgt_valid_q <= req && allowed;
            tgt_sel_q <= allowed ? sel : `RDP_TGT_NONE;
            tgt_slot_q <= slot;
            tgt_addr_q <= eff_addr;
            tgt_write_q <= req && allowed && write;
            resp_valid_q <= req;
            resp_q <= (req && !allowed) ? `RDP_RESP_ERROR : `RDP_RESP_OKAY;
            fault_q <= req && !allowed;
        end
    end
endmodule
`default_nettype wire

// ===== verif/rdp_top_sva.sv
/* Checker on the ports of rdp_top.
   Assumes the bind below attaches it. */
`timescale 1ns/1ps
`default_nettype none
module rdp_top_sva (
    input wire clk,
    input wire reset,
    input wire req,
    input wire write,
    input wire tgt_valid_q,
    input wire [2:0] tgt_sel_q,
    input wire [6:0] tgt_slot_q,
    input wire [31:0] tgt_addr_q,
    input wire tgt_write_q,
    input wire resp_valid_q,
    input wire resp_q,
    input wire fault_q
);
    // One clock; reset stands every check down.
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ans_next: assert property (req |=> resp_valid_q) else $error("late");
    a_no_stray: assert property (!req |=> !resp_valid_q && !tgt_valid_q) else $error("stray");
    a_fault_blocks: assert property (fault_q |-> resp_q && !tgt_write_q && !tgt_sel_q) else $error("leak");
    a_err_pairs: assert property (resp_valid_q |-> resp_q == fault_q && tgt_valid_q != fault_q) else $error("pair");
    a_write_echo: assert property (req ##1 tgt_valid_q |-> tgt_write_q == $past(write)) else $error("dir");
    a_fast_slot: assert property (tgt_sel_q == 3'h5 |-> tgt_slot_q == tgt_addr_q[20:14]) else $error("fast");
    a_slow_slot: assert property (tgt_sel_q == 3'h4 |-> tgt_slot_q == {1'b0, tgt_addr_q[19:14]}) else $error("slow");
    a_ram_block: assert property (tgt_sel_q == 3'h3 |-> tgt_slot_q == {6'h00, tgt_addr_q[14]}) else $error("ram");
    c_fault: cover property (req ##1 fault_q);
    c_fast: cover property (tgt_sel_q == 3'h5);
    c_burst: cover property (resp_valid_q [*3]);
endmodule
bind rdp_top rdp_top_sva i_rdp_top_sva (.clk, .reset, .req, .write, .tgt_valid_q, .tgt_sel_q, .tgt_slot_q,
    .tgt_addr_q, .tgt_write_q, .resp_valid_q, .resp_q, .fault_q);
`default_nettype wire

// ===== verif/rdp_master.sv
/* Bus master model, one access per call.
   Assumes calls just after a falling edge. */
`timescale 1ns/1ps
`default_nettype none
module rdp_master (
    output var logic req,
    output var logic [31:0] addr,
    output var logic write,
    output var logic vec_fetch
);
    // Idle cycles show inverted fields, so a stale access never looks live.
    task put(input logic r, input logic [31:0] a, input logic w, input logic v);
        req = r;
        addr = r ? a : ~a;
        write = r ? w : ~w;
        vec_fetch = r ? v : ~v;
    endtask
    initial put(1'b0, 32'h0000_0000, 1'b0, 1'b0);
endmodule
`default_nettype wire

// ===== verif/region_decode_protect_bench.sv
/* Random bench for rdp_top.
   Assumes the master model and checker. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module region_decode_protect_bench;
    logic clk = 0, reset = 1, remap_en = 0, req, write, vec_fetch, pv = 0, pw, tgt_valid_q, tgt_write_q;
    logic resp_valid_q, resp_q, fault_q;
    logic [2:0] tgt_sel_q, k;
    logic [6:0] tgt_slot_q;
    logic [7:0] st;
    logic [31:0] addr, tgt_addr_q, remap_base = 32'h1000_0000, a, r, x = 32'h0000_2C1F;
    logic [31:0] bases [6] = '{32'h0000_0000, 32'h1000_0000, 32'h2007_C000, 32'h4000_0000, 32'h5000_0000, 32'h6000_0000};
    logic [42:0] pe;
    int errors = 0, tests_run = 0, cyc = 0;
    // Low 2 GB open, main RAM read-only, first RAM block and slow slot 0 above 2 kB shut, upper fast half bare.
    logic [7:0] reg_enable = 8'h3F;
    logic [255:0] reg_base = 256'h5000_0000_4000_0000_2007_C000_1000_0000_4000_0000_0000_0000;
    logic [39:0] reg_size = 40'h00_28E7_3FDE;
    logic [63:0] reg_subdis = 64'h0000_0001_0000_0400;
    logic [15:0] reg_perm = 16'h081A;
    assign st = {resp_valid_q, fault_q, resp_q, tgt_valid_q, tgt_write_q, tgt_sel_q};
    rdp_top i_rdp_top (.clk, .reset, .req, .addr, .write, .vec_fetch, .remap_en, .remap_base, .reg_enable,
        .reg_base, .reg_size, .reg_subdis, .reg_perm, .tgt_valid_q, .tgt_sel_q, .tgt_slot_q, .tgt_addr_q,
        .tgt_write_q, .resp_valid_q, .resp_q, .fault_q);
    rdp_master i_rdp_master (.req, .addr, .write, .vec_fetch);
    // Xorshift source with a fixed seed.
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // Expected fault, target, slot and effective address; p is 2 open, 1 read-only, 0 shut, 3 bare.
    function automatic logic [42:0] exp_of(input logic [31:0] a, input logic w, input logic v);
        logic [31:0] e;
        logic [2:0] s;
        logic [6:0] n;
        logic [1:0] p;
        logic f;
        e = v && a < 32'h0000_0200 ? {remap_base[31:9], a[8:0]} : a;
        {s, n, p} = 12'h002;
        if (e < 32'h0008_0000) s = 3'h1;
        else if (e - 32'h1000_0000 < 32'h0000_8000) {s, p} = 5'h09;
        else if (e - 32'h2007_C000 < 32'h0000_8000) {s, n, p} = {3'h3, 6'h00, e[14], !e[14], 1'b0};
        else if (e[31:20] == 12'h400) {s, n, p} = {4'h8, e[19:14], e[19:14] != 6'h00 || e[13:11] == 3'h0, 1'b0};
        else if (e[31:21] == 11'h280) {s, n, p} = {3'h5, e[20:14], 1'b1, e[20]};
        f = s == 3'h0 || p != 2'h2 && !(p == 2'h1 && !w);
        return {f, f ? 3'h0 : s, n, e};
    endfunction
    task results();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    // About 512 cycles are needed; a hang is cut well beyond that.
    always @(posedge clk) if (++cyc > 1000) begin
        errors++;
        results();
    end
    // Back-to-back accesses; half are kept inside the first 32 kB so slot and subregion edges get hit.
    initial begin
        repeat (12) @(negedge clk);
        reset = 0;
        repeat (500) begin
            @(negedge clk);
            if (pv) `CHK(st, {1'b1, {2{pe[42]}}, !pe[42], pw, pe[41:39]})
            else `CHK(st[7:4], 4'h0)
            if (pv && !pe[42]) `CHK({tgt_slot_q, tgt_addr_q}, pe[38:0])
            r = rnd();
            k = r[2:0] % 6;
            a = bases[k] | rnd() & (r[25] ? 32'h0000_7FFF : 32'h001F_FFFF);
            if (r[31:30] == 2'h3) a = a & 32'h0000_01FF;
            remap_en = r[29];
            remap_base = r[28] ? 32'h2008_0000 : 32'h1000_0000;
            pv = r[7:3] != 5'h00;
            pe = exp_of(a, r[27], r[26] && r[29]);
            pw = r[27] && !pe[42];
            i_rdp_master.put(pv, a, r[27], r[26]);
        end
        results();
    end
endmodule
`default_nettype wire
